// >>> tsic_pkg.sv
// Shared constants for the three source interrupt controller
package tsic_pkg;

	// Program counter width
	localparam int PC_W = 10;

	// Control register width and field positions
	localparam int CTRL_W      = 7;
	localparam int POS_GLOBAL  = 0;
	localparam int POS_EXT_EN  = 1;
	localparam int POS_TMR_EN  = 2;
	localparam int POS_CONV_EN = 3;
	localparam int POS_FLAG0   = 4;

	// Number of sources, index order is priority order
	localparam int NSRC    = 3;
	localparam int SRC_EXT = 0;
	localparam int SRC_TMR = 1;
	localparam int SRC_CNV = 2;

	// Reset value of the control register
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

	// Fixed service addresses and program counter reset value
	localparam logic [PC_W-1:0] VEC_EXT = 10'h004;
	localparam logic [PC_W-1:0] VEC_TMR = 10'h008;
	localparam logic [PC_W-1:0] VEC_CNV = 10'h00C;
	localparam logic [PC_W-1:0] PC_RST  = 10'h000;

endpackage : tsic_pkg

// >>> tsic_sel_if.sv
// Request and grant carrier between controller and priority selector
`timescale 1ns/1ps
interface tsic_sel_if;
	logic [tsic_pkg::NSRC-1:0] req;
	logic [tsic_pkg::NSRC-1:0] grant;
	logic [tsic_pkg::PC_W-1:0] vec;
	logic                      any;

	modport ctrl (output req, input grant, input vec, input any);
	modport sel  (input req, output grant, output vec, output any);
endinterface : tsic_sel_if

// >>> tsic_prio.sv
// Fixed priority selector with vector lookup
`timescale 1ns/1ps
module tsic_prio (
	// Request and grant carrier
	tsic_sel_if.sel s
);
	wire logic g_ext;
	wire logic g_tmr;
	wire logic g_cnv;

	assign g_ext = s.req[tsic_pkg::SRC_EXT];
	assign g_tmr = s.req[tsic_pkg::SRC_TMR] & ~g_ext;
	assign g_cnv = s.req[tsic_pkg::SRC_CNV] & ~g_ext & ~g_tmr;

	assign s.grant = {g_cnv, g_tmr, g_ext};
	assign s.any   = |s.req;
	assign s.vec   = g_ext ? tsic_pkg::VEC_EXT :
	                 g_tmr ? tsic_pkg::VEC_TMR :
	                 tsic_pkg::VEC_CNV;

endmodule : tsic_prio

// >>> tsic_ctrl.sv
// Three source interrupt controller top
`timescale 1ns/1ps
module tsic_ctrl (
	// Clock, reset, enable
	input  wire logic                        i_clock,
	input  wire logic                        i_arst_n,
	input  wire logic                        i_clk_en,
	// Phase-two sampling pulse
	input  wire logic                        i_second_phase_pulse,
	// Control register write port
	input  wire logic                        i_ctrl_wr,
	input  wire logic [tsic_pkg::CTRL_W-1:0] i_ctrl_wdata,
	// Shared pin and its configuration
	input  wire logic                        i_port_a_bit_five,
	input  wire logic                        i_port_a_direction_bit_five,
	input  wire logic                        i_cfg_ext_func,
	input  wire logic                        i_cfg_ext_rising,
	input  wire logic                        i_cfg_pull_high,
	// Internal sources
	input  wire logic                        i_timer_overflow,
	input  wire logic                        i_conv_done,
	// Core sequencer and return stack
	input  wire logic [tsic_pkg::PC_W-1:0]   i_next_pc,
	input  wire logic                        i_stack_full,
	input  wire logic                        i_reti,
	input  wire logic [tsic_pkg::PC_W-1:0]   i_ret_pc,
	// Status
	output logic [tsic_pkg::CTRL_W-1:0]      o_irq_control_reg,
	output logic                             o_wake,
	output logic                             o_pull_high_en,
	// Core control
	output logic                             o_stack_push,
	output logic [tsic_pkg::PC_W-1:0]        o_push_pc,
	output logic                             o_stack_pop,
	output logic                             o_pc_load,
	output logic [tsic_pkg::PC_W-1:0]        o_pc_value
);

	tsic_sel_if sel ();

	logic [tsic_pkg::CTRL_W-1:0] ctrl_q;
	logic [tsic_pkg::CTRL_W-1:0] ctrl_d;
	logic                        pin_s1_q;
	logic                        pin_s2_q;
	logic                        pin_prev_q;
	logic                        wake_q;
	logic                        push_q;
	logic                        pop_q;
	logic                        load_q;
	logic [tsic_pkg::PC_W-1:0]   push_pc_q;
	logic [tsic_pkg::PC_W-1:0]   pc_q;

	wire logic                      glob;
	wire logic [tsic_pkg::NSRC-1:0] en;
	wire logic [tsic_pkg::NSRC-1:0] flag;
	wire logic [tsic_pkg::NSRC-1:0] set;
	wire logic [tsic_pkg::NSRC-1:0] clr;
	wire logic [tsic_pkg::NSRC-1:0] flag_d;
	wire logic                      pin_rise;
	wire logic                      pin_fall;
	wire logic                      pin_used;
	wire logic                      ext_edge;
	wire logic                      take;
	wire logic                      ret;
	wire logic                      glob_d;

	// Field decode
	assign glob = ctrl_q[tsic_pkg::POS_GLOBAL];
	assign en   = ctrl_q[tsic_pkg::POS_CONV_EN:tsic_pkg::POS_EXT_EN];
	assign flag = ctrl_q[tsic_pkg::CTRL_W-1:tsic_pkg::POS_FLAG0];

	// Pin edge detect after synchroniser
	assign pin_rise = pin_s2_q & ~pin_prev_q;
	assign pin_fall = ~pin_s2_q & pin_prev_q;
	assign pin_used = i_cfg_ext_func & i_port_a_direction_bit_five;
	assign ext_edge = pin_used &
	                  (i_cfg_ext_rising ? pin_rise : pin_fall);

	// Source events
	assign set[tsic_pkg::SRC_EXT] = ext_edge;
	assign set[tsic_pkg::SRC_TMR] = i_timer_overflow;
	assign set[tsic_pkg::SRC_CNV] = i_conv_done;

	// Enabled pending requests to the selector
	assign sel.req = flag & en;

	// Service on phase-two pulse when allowed
	assign ret  = i_clk_en & i_reti;
	assign take = i_clk_en & i_second_phase_pulse & glob &
	              sel.any & ~i_stack_full & ~i_reti;

	// Flag update, set wins over any clear
	genvar gi;
	generate
		for (gi = 0; gi < tsic_pkg::NSRC; gi++) begin : g_flag
			assign clr[gi] = (take & sel.grant[gi]) |
			                 (i_ctrl_wr &
			                  ~i_ctrl_wdata[tsic_pkg::POS_FLAG0 + gi]);
			assign flag_d[gi] = set[gi] |
			                    (flag[gi] & ~clr[gi]) |
			                    (i_ctrl_wr &
			                     i_ctrl_wdata[tsic_pkg::POS_FLAG0 + gi]);
		end
	endgenerate

	// Global enable: service clears, return sets, else software
	assign glob_d = take ? 1'b0 :
	                ret ? 1'b1 :
	                i_ctrl_wr ? i_ctrl_wdata[tsic_pkg::POS_GLOBAL] :
	                glob;

	assign ctrl_d = {flag_d,
	                 i_ctrl_wr ?
	                 i_ctrl_wdata[tsic_pkg::POS_CONV_EN:tsic_pkg::POS_EXT_EN] :
	                 en,
	                 glob_d};

	// Selector
	tsic_prio u_prio (
		.s (sel.sel)
	);

	// Pin synchroniser
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_q   <= 1'b1;
			pin_s2_q   <= 1'b1;
			pin_prev_q <= 1'b1;
		end else if (i_clk_en) begin
			pin_s1_q   <= i_port_a_bit_five;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Control register and wake
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q <= tsic_pkg::CTRL_RST;
			wake_q <= 1'b0;
		end else if (i_clk_en) begin
			ctrl_q <= ctrl_d;
			wake_q <= |set;
		end
	end

	// Core sequencer commands
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			push_q    <= 1'b0;
			pop_q     <= 1'b0;
			load_q    <= 1'b0;
			push_pc_q <= tsic_pkg::PC_RST;
			pc_q      <= tsic_pkg::PC_RST;
		end else if (i_clk_en) begin
			push_q <= take;
			pop_q  <= ret;
			load_q <= take | ret;
			if (take) begin
				push_pc_q <= i_next_pc;
				pc_q      <= sel.vec;
			end else if (ret) begin
				pc_q      <= i_ret_pc;
			end
		end
	end

	// Outputs
	assign o_irq_control_reg = ctrl_q;
	assign o_wake            = wake_q;
	assign o_pull_high_en    = i_cfg_pull_high;
	assign o_stack_push      = push_q;
	assign o_push_pc         = push_pc_q;
	assign o_stack_pop       = pop_q;
	assign o_pc_load         = load_q;
	assign o_pc_value        = pc_q;

	// Checks
	property p_glob_gate;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_second_phase_pulse && !glob) |=> !o_stack_push;
	endproperty
	a_glob_gate: assert property (p_glob_gate)
		else $error("service while global enable low");

	property p_push_vec;
		@(posedge i_clock) disable iff (!i_arst_n)
		o_stack_push |-> o_pc_load && (o_pc_value == tsic_pkg::VEC_EXT ||
		o_pc_value == tsic_pkg::VEC_TMR || o_pc_value == tsic_pkg::VEC_CNV);
	endproperty
	a_push_vec: assert property (p_push_vec)
		else $error("push without vector load");

	property p_clear_glob;
		@(posedge i_clock) disable iff (!i_arst_n)
		take |=> !glob;
	endproperty
	a_clear_glob: assert property (p_clear_glob)
		else $error("global enable not cleared on service");

	property p_stack_full;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_stack_full) |=> !o_stack_push;
	endproperty
	a_stack_full: assert property (p_stack_full)
		else $error("service with stack full");

	property p_reti;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_reti) |=> o_stack_pop && o_pc_load && glob &&
		o_pc_value == $past(i_ret_pc);
	endproperty
	a_reti: assert property (p_reti)
		else $error("return did not restore pc");

	property p_t2;
		@(posedge i_clock) disable iff (!i_arst_n)
		$rose(o_stack_push) |-> $past(i_second_phase_pulse);
	endproperty
	a_t2: assert property (p_t2)
		else $error("service off the phase-two pulse");

	property p_prio;
		@(posedge i_clock) disable iff (!i_arst_n)
		(take && flag[tsic_pkg::SRC_EXT] && en[tsic_pkg::SRC_EXT])
		|=> o_pc_value == tsic_pkg::VEC_EXT;
	endproperty
	a_prio: assert property (p_prio)
		else $error("external request lost priority");

	property p_set_tmr;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_timer_overflow) |=> flag[tsic_pkg::SRC_TMR];
	endproperty
	a_set_tmr: assert property (p_set_tmr)
		else $error("timer overflow did not set flag");

	property p_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		(flag[tsic_pkg::SRC_CNV] && !take && !i_ctrl_wr)
		|=> flag[tsic_pkg::SRC_CNV];
	endproperty
	a_hold: assert property (p_hold)
		else $error("conversion flag dropped");

	property p_set_cnv;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_conv_done) |=> flag[tsic_pkg::SRC_CNV];
	endproperty
	a_set_cnv: assert property (p_set_cnv)
		else $error("conversion end did not set flag");

	property p_set_ext;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && ext_edge) |=> flag[tsic_pkg::SRC_EXT];
	endproperty
	a_set_ext: assert property (p_set_ext)
		else $error("pin edge did not set external flag");

	property p_ext_quiet;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && !ext_edge && !i_ctrl_wr && !flag[tsic_pkg::SRC_EXT])
		|=> !flag[tsic_pkg::SRC_EXT];
	endproperty
	a_ext_quiet: assert property (p_ext_quiet)
		else $error("external flag set without pin edge");

	property p_wake;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && (|set)) |=> o_wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("source event did not raise wake");

	property p_push_pc;
		@(posedge i_clock) disable iff (!i_arst_n)
		take |=> o_push_pc == $past(i_next_pc);
	endproperty
	a_push_pc: assert property (p_push_pc)
		else $error("pushed address is not next instruction");

	property p_svc_clr;
		@(posedge i_clock) disable iff (!i_arst_n)
		(take && sel.grant[tsic_pkg::SRC_TMR] && !i_timer_overflow &&
		!i_ctrl_wr) |=> !flag[tsic_pkg::SRC_TMR];
	endproperty
	a_svc_clr: assert property (p_svc_clr)
		else $error("serviced timer flag not cleared");

	property p_tmr_prio;
		@(posedge i_clock) disable iff (!i_arst_n)
		(take && sel.req[tsic_pkg::SRC_TMR] && !sel.req[tsic_pkg::SRC_EXT])
		|=> o_pc_value == tsic_pkg::VEC_TMR;
	endproperty
	a_tmr_prio: assert property (p_tmr_prio)
		else $error("timer request lost priority");

	property p_onehot;
		@(posedge i_clock) disable iff (!i_arst_n)
		sel.any |-> $onehot(sel.grant);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("grant not one-hot");

	property p_one_pulse;
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_stack_push && i_clk_en) |=> !o_stack_push;
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("service repeated without re-enable");

	property p_freeze;
		@(posedge i_clock) disable iff (!i_arst_n)
		!i_clk_en |=> $stable(ctrl_q) && $stable(pc_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state changed while clock enable low");

	c_ext_svc: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		take && sel.grant[tsic_pkg::SRC_EXT]);
	c_tmr_svc: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		take && sel.grant[tsic_pkg::SRC_TMR]);
	c_ret: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		o_stack_push ##[1:50] o_stack_pop);
	c_cnv_svc: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		take && sel.grant[tsic_pkg::SRC_CNV]);
	c_full_hold: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		i_second_phase_pulse && glob && sel.any && i_stack_full);

endmodule : tsic_ctrl

// >>> tsic_core_model.sv
// Core sequencer and return stack model facing the controller
`timescale 1ns/1ps
module tsic_core_model #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_arst_n,
	// Controller requests
	input  wire logic                      i_push,
	input  wire logic [tsic_pkg::PC_W-1:0] i_push_pc,
	input  wire logic                      i_pop,
	input  wire logic                      i_pc_load,
	input  wire logic [tsic_pkg::PC_W-1:0] i_pc_value,
	// Core state seen by the controller
	output logic [tsic_pkg::PC_W-1:0]      o_next_pc,
	output logic [tsic_pkg::PC_W-1:0]      o_ret_pc,
	output logic                           o_full
);
	logic [tsic_pkg::PC_W-1:0] stack_q [DEPTH];
	int                        level_q;
	logic [tsic_pkg::PC_W-1:0] pc_q;

	assign o_full    = (level_q >= DEPTH);
	assign o_ret_pc  = (level_q > 0) ? stack_q[level_q-1] : ~pc_q;
	assign o_next_pc = pc_q;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			level_q <= 0;
			pc_q    <= 10'h100;
		end else begin
			pc_q <= i_pc_load ? i_pc_value : pc_q + 10'h001;
			if (i_push && level_q < DEPTH) begin
				stack_q[level_q] <= i_push_pc;
				level_q          <= level_q + 1;
			end else if (i_pop && level_q > 0) begin
				level_q <= level_q - 1;
			end
		end
	end
endmodule : tsic_core_model

// >>> three_source_interrupt_control_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module three_source_interrupt_control_tb;
	logic clk = 0, arst_n = 0, pulse = 0, wr = 0, pin = 0, pull = 0;
	logic tmr = 0, conv = 0, reti = 0, full, push, pop, load, wake, pull_en;
	logic clk_en = 1, dir = 1, func = 1, rising = 1;
	logic [6:0] wdata = 7'h00, reg_q;
	logic [9:0] npc, rpc, push_pc, pc_val;
	logic [9:0] saved [$];
	int fails = 0, n_compared = 0, cycles = 0;

	always #4 clk = ~clk;

	tsic_ctrl DUT (.i_clock(clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
		.i_second_phase_pulse(pulse), .i_ctrl_wr(wr), .i_ctrl_wdata(wdata),
		.i_port_a_bit_five(pin), .i_port_a_direction_bit_five(dir),
		.i_cfg_ext_func(func), .i_cfg_ext_rising(rising),
		.i_cfg_pull_high(pull), .i_timer_overflow(tmr), .i_conv_done(conv),
		.i_next_pc(npc), .i_stack_full(full), .i_reti(reti), .i_ret_pc(rpc),
		.o_irq_control_reg(reg_q), .o_wake(wake), .o_pull_high_en(pull_en),
		.o_stack_push(push), .o_push_pc(push_pc), .o_stack_pop(pop),
		.o_pc_load(load), .o_pc_value(pc_val));

	tsic_core_model #(.DEPTH(2)) core (.i_clock(clk), .i_arst_n(arst_n),
		.i_push(push), .i_push_pc(push_pc), .i_pop(pop), .i_pc_load(load),
		.i_pc_value(pc_val), .o_next_pc(npc), .o_ret_pc(rpc), .o_full(full));

	task tick;
		@(negedge clk);
	endtask : tick

	task wr_reg(input logic [6:0] v);
		wr = 1; wdata = v; tick(); wr = 0;
	endtask : wr_reg

	task service(input logic [9:0] vec, input logic [6:0] exp_reg);
		saved.push_back(npc);
		pulse = 1; tick(); pulse = 0;
		`CHK("push", 1'b1, push)
		`CHK("push_pc", saved[$], push_pc)
		`CHK("vector", vec, pc_val)
		`CHK("load", 1'b1, load)
		`CHK("reg", exp_reg, reg_q)
		tick();
		`CHK("push_end", 1'b0, push)
	endtask : service

	task ret(input logic [6:0] exp_reg);
		logic [9:0] exp_pc;
		exp_pc = saved.pop_back();
		reti = 1;
		tick();
		reti = 0;
		`CHK("pop", 1'b1, pop)
		`CHK("ret_pc", exp_pc, pc_val)
		`CHK("ret_reg", exp_reg, reg_q)
		tick();
	endtask : ret

	task no_service(input logic [6:0] exp_reg);
		pulse = 1; tick(); pulse = 0;
		`CHK("no_push", 1'b0, push)
		`CHK("held_reg", exp_reg, reg_q)
	endtask : no_service

	task t_sources;
		`CHK("reset_reg", tsic_pkg::CTRL_RST, reg_q)
		`CHK("pull", 1'b0, pull_en)
		pull = 1; tmr = 1; conv = 1; tick(); tmr = 0; conv = 0;
		`CHK("pull", 1'b1, pull_en)
		`CHK("src_reg", 7'h60, reg_q)
		`CHK("wake", 1'b1, wake)
		pin = 1; repeat (5) tick();
		`CHK("pin_flag", 7'h70, reg_q)
		wr_reg(7'h7E);
		no_service(7'h7E);
	endtask : t_sources

	task t_prio;
		wr_reg(7'h7F);
		service(tsic_pkg::VEC_EXT, 7'h6E);
		no_service(7'h6E);
		ret(7'h6F);
		service(tsic_pkg::VEC_TMR, 7'h4E);
		ret(7'h4F);
		service(tsic_pkg::VEC_CNV, 7'h0E);
		ret(7'h0F);
	endtask : t_prio

	task t_full;
		wr_reg(7'h6F);
		service(tsic_pkg::VEC_TMR, 7'h4E);
		wr_reg(7'h4F);
		service(tsic_pkg::VEC_CNV, 7'h0E);
		tmr = 1; tick(); tmr = 0;
		`CHK("pend_tmr", 7'h2E, reg_q)
		wr_reg(7'h2F);
		no_service(7'h2F);
		ret(7'h2F);
		service(tsic_pkg::VEC_TMR, 7'h0E);
		ret(7'h0F);
		ret(7'h0F);
	endtask : t_full

	task t_hold;
		wr_reg(7'h01);
		tmr = 1; tick(); tmr = 0;
		no_service(7'h21);
		wr_reg(7'h01);
		`CHK("cleared", 7'h01, reg_q)
	endtask : t_hold

	task pin_step(input logic v, input logic [6:0] exp_reg);
		pin = v;
		repeat (5) tick();
		`CHK("pin_reg", exp_reg, reg_q)
	endtask : pin_step

	task t_pin;
		rising = 0;
		func = 0;
		pin_step(1'b0, 7'h01);
		func = 1;
		dir = 0;
		pin_step(1'b1, 7'h01);
		pin_step(1'b0, 7'h01);
		dir = 1;
		pin_step(1'b1, 7'h01);
		pin_step(1'b0, 7'h11);
		clk_en = 0;
		tmr = 1;
		tick();
		tmr = 0;
		`CHK("frozen_reg", 7'h11, reg_q)
		`CHK("frozen_wake", 1'b0, wake)
		clk_en = 1;
		tick();
		`CHK("thawed_reg", 7'h11, reg_q)
		wr_reg(7'h13);
		tick();
		`CHK("no_pulse", 1'b0, push)
		service(tsic_pkg::VEC_EXT, 7'h02);
		ret(7'h03);
		pin_step(1'b1, 7'h03);
	endtask : t_pin

	task t_reset;
		arst_n = 0;
		tick();
		`CHK("rst_reg", tsic_pkg::CTRL_RST, reg_q)
		`CHK("rst_load", 1'b0, load)
		arst_n = 1;
		repeat (2) tick();
		`CHK("post_rst_reg", tsic_pkg::CTRL_RST, reg_q)
		`CHK("post_rst_pc", tsic_pkg::PC_RST, pc_val)
	endtask : t_reset

	task results;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end

	initial begin
		repeat (20) tick();
		arst_n = 1;
		tick();
		t_sources();
		t_prio();
		t_full();
		t_hold();
		t_pin();
		t_reset();
		results();
	end
endmodule : three_source_interrupt_control_tb
